// file: fault_collector.sv
`timescale 1ns/1ps
`default_nettype none

module fault_collector
	import touch_diag_pkg::*;
#(
	parameter int N_BUTTONS = 10
)(
	input  wire logic                 clk_sys,
	input  wire logic                 reset,
	input  wire logic                 ce,
	input  wire logic [N_BUTTONS-1:0] gnd_fault_set,
	input  wire logic [N_BUTTONS-1:0] cap_fault_set,
	input  wire logic                 pair_fault_valid,
	input  wire logic [3:0]           pair_fault_a,
	input  wire logic [3:0]           pair_fault_b,
	output logic      [N_BUTTONS-1:0] gnd_flags,
	output logic      [N_BUTTONS-1:0] pair_flags,
	output logic      [N_BUTTONS-1:0] cap_flags,
	output logic      [N_BUTTONS-1:0] sense_enable
);

	// ----------------------------------------------------------------
	// index to one-hot, used for both buttons of a shorted pair
	// ----------------------------------------------------------------
	function automatic logic [N_BUTTONS-1:0] one_hot(input logic [3:0] idx);
		logic [N_BUTTONS-1:0] v;
		v = '0;
		for (int i = 0; i < N_BUTTONS; i++)
			v[i] = (idx == 4'(i));
		return v;
	endfunction

	wire logic [N_BUTTONS-1:0] pair_set;

	// a detected pair marks both buttons at once
	assign pair_set = pair_fault_valid ? (one_hot(pair_fault_a) | one_hot(pair_fault_b))
		: '0; // R13

	// ----------------------------------------------------------------
	// per-button sticky fault flags, kept until reset is asserted
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < N_BUTTONS; g++)
		begin : g_btn
			logic gnd_q;
			logic pair_q;
			logic cap_q;
			always_ff @(posedge clk_sys or posedge reset)
			begin
				if (reset)
				begin
					gnd_q  <= 1'b0;
					pair_q <= 1'b0;
					cap_q  <= 1'b0;
				end
				else if (ce)
				begin
					gnd_q  <= gnd_q | gnd_fault_set[g];  // R12
					pair_q <= pair_q | pair_set[g];      // R13
					cap_q  <= cap_q | cap_fault_set[g];  // R14
				end
			end
			assign gnd_flags[g]  = gnd_q;
			assign pair_flags[g] = pair_q;
			assign cap_flags[g]  = cap_q;
			// any fault removes the button from sensing
			assign sense_enable[g] = ~(gnd_q | pair_q | cap_q); // R9
		end
	endgenerate

endmodule // fault_collector

`default_nettype wire

// file: host_port_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// host side of the register port
// ----------------------------------------------------------------
module host_port_model (
	input  wire logic       clk_sys,
	output logic            reg_wr_en,
	output logic            reg_rd_en,
	output logic      [7:0] reg_addr,
	output logic      [7:0] reg_wr_data,
	input  wire logic [7:0] reg_rd_data,
	input  wire logic       reg_rd_valid
);

	// idle bus at time zero
	initial
	begin
		reg_wr_en   = 1'b0;
		reg_rd_en   = 1'b0;
		reg_addr    = 8'h00;
		reg_wr_data = 8'h00;
	end

	// one write, held until the taking edge, then released
	task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
		@(posedge clk_sys);
		reg_wr_en   <= 1'b1;
		reg_addr    <= addr;
		reg_wr_data <= data;
		@(posedge clk_sys);
		reg_wr_en   <= 1'b0;
		reg_addr    <= ~addr; // released bus shows no stale value
		reg_wr_data <= ~data;
	endtask

	// one read; the answer stands for one cycle after the taking edge
	task automatic read_reg(input logic [7:0] addr, output logic [7:0] data,
		output logic valid);
		@(posedge clk_sys);
		reg_rd_en <= 1'b1;
		reg_addr  <= addr;
		@(posedge clk_sys);
		reg_rd_en <= 1'b0;
		reg_addr  <= ~addr;
		#1;
		data  = reg_rd_data;
		valid = reg_rd_valid;
	endtask

endmodule // host_port_model

`default_nettype wire

// file: test_touch_button_diag_register_bank.sv
`timescale 1ns/1ps
`default_nettype none
`include "touch_diag_defs.svh"
`define CHECK(g, e) compare_val(16'(g), 16'(e))

module test_touch_button_diag_register_bank;
	import touch_diag_pkg::*;

	logic       clk_sys, reset, ce, wr_en, rd_en, rd_valid, pair_valid, diag_done;
	logic [7:0] addr, wr_data, rd_data;
	logic [9:0] raw_touch, gnd_set, cap_set, sense_enable;
	logic [3:0] pair_a, pair_b, host_out;
	op_mode_t   device_mode;
	int         n_errors;
	int         compares;

	// ----------------------------------------------------------------
	// clock, design and host
	// ----------------------------------------------------------------
	always #2 clk_sys = ~clk_sys;

	touch_button_diag_register_bank dut (.clk_sys(clk_sys), .reset(reset), .ce(ce),
		.reg_wr_en(wr_en), .reg_rd_en(rd_en), .reg_addr(addr), .reg_wr_data(wr_data),
		.reg_rd_data(rd_data), .reg_rd_valid(rd_valid), .raw_touch(raw_touch),
		.gnd_fault_set(gnd_set), .cap_fault_set(cap_set), .pair_fault_valid(pair_valid),
		.pair_fault_a(pair_a), .pair_fault_b(pair_b), .diag_done(diag_done),
		.host_driven_output(host_out), .device_mode(device_mode),
		.sense_enable(sense_enable));

	host_port_model host (.clk_sys(clk_sys), .reg_wr_en(wr_en), .reg_rd_en(rd_en),
		.reg_addr(addr), .reg_wr_data(wr_data), .reg_rd_data(rd_data),
		.reg_rd_valid(rd_valid));

	// ----------------------------------------------------------------
	// checking helpers
	// ----------------------------------------------------------------
	task automatic compare_val(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp)
		begin
			n_errors++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// read one register and compare data and valid pulse
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		logic       v;
		host.read_reg(a, d, v);
		`CHECK(v, 1'b1);
		`CHECK(d, exp);
	endtask

	task automatic close_out;
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	// reset values of outputs and of every mapped register
	task automatic t_reset;
		logic [7:0] offs [9];
		offs = '{`TD_OFF_TALLY, `TD_OFF_TOUCH_LO, `TD_OFF_TOUCH_HI, `TD_OFF_GND_LO,
			`TD_OFF_GND_HI, `TD_OFF_PAIR_LO, `TD_OFF_PAIR_HI, `TD_OFF_CAP_LO,
			`TD_OFF_CAP_HI};
		`CHECK(host_out, 4'h0);
		`CHECK(device_mode, MODE_LINE_TEST);
		`CHECK(sense_enable, 10'h3FF);
		`CHECK(rd_valid, 1'b0);
		`CHECK(rd_data, `TD_RST_STATUS);
		rd_chk(`TD_OFF_CONTROL, `TD_RST_CONTROL);
		foreach (offs[i])
			rd_chk(offs[i], `TD_RST_STATUS);
	endtask

	// every mode code, invalid ones keep the old mode
	task automatic t_control;
		logic [2:0] mode_exp;
		logic [3:0] out_exp;
		mode_exp = 3'b011;
		for (int m = 0; m < 8; m++)
		begin
			out_exp = 4'(m * 3 + 1);
			host.write_reg(`TD_OFF_CONTROL, {out_exp, 1'b0, 3'(m)});
			if (m < 5)
				mode_exp = 3'(m);
			@(posedge clk_sys);
			`CHECK(host_out, out_exp);
			`CHECK(device_mode, mode_exp);
			rd_chk(`TD_OFF_CONTROL, {out_exp, 1'b0, mode_exp});
		end
		host.write_reg(`TD_OFF_CONTROL, 8'h80);
		@(posedge clk_sys);
		`CHECK(host_out, 4'b1000);
	endtask

	// writes to read-only and reserved offsets change nothing
	task automatic t_read_only;
		host.write_reg(`TD_OFF_TOUCH_LO, 8'hFF);
		host.write_reg(`TD_OFF_GND_LO, 8'hFF);
		host.write_reg(`TD_OFF_TALLY, 8'hFF);
		host.write_reg(8'h01, 8'hFF);
		rd_chk(`TD_OFF_TOUCH_LO, 8'h00);
		rd_chk(`TD_OFF_GND_LO, 8'h00);
		rd_chk(`TD_OFF_TALLY, 8'h00);
		rd_chk(8'h01, 8'h00);
		rd_chk(`TD_OFF_CONTROL, 8'h80);
	endtask

	// live touch state split across the register pair
	task automatic t_touch;
		@(posedge clk_sys);
		raw_touch <= 10'h2A5;
		repeat (2) @(posedge clk_sys);
		rd_chk(`TD_OFF_TOUCH_LO, 8'hA5);
		rd_chk(`TD_OFF_TOUCH_HI, 8'h02);
	endtask

	// ground, capacitance and pair faults flag and disable buttons
	task automatic t_faults;
		@(posedge clk_sys);
		gnd_set    <= 10'h004;
		cap_set    <= 10'h200;
		pair_valid <= 1'b1;
		pair_a     <= 4'd1;
		pair_b     <= 4'd8;
		raw_touch  <= 10'h3FF;
		@(posedge clk_sys);
		gnd_set    <= 10'h000;
		cap_set    <= 10'h000;
		pair_valid <= 1'b0;
		@(posedge clk_sys);
		#1;
		`CHECK(sense_enable, 10'h0F9);
		rd_chk(`TD_OFF_GND_LO, 8'h04);
		rd_chk(`TD_OFF_GND_HI, 8'h00);
		rd_chk(`TD_OFF_PAIR_LO, 8'h02);
		rd_chk(`TD_OFF_PAIR_HI, 8'h01);
		rd_chk(`TD_OFF_CAP_LO, 8'h00);
		rd_chk(`TD_OFF_CAP_HI, 8'h02);
		rd_chk(`TD_OFF_TOUCH_LO, 8'hF9);
		rd_chk(`TD_OFF_TOUCH_HI, 8'h00);
	endtask

	// tally counts the buttons left usable
	task automatic t_tally;
		logic [7:0] d;
		logic       v;
		@(posedge clk_sys);
		diag_done <= 1'b1;
		@(posedge clk_sys);
		diag_done <= 1'b0;
		host.read_reg(`TD_OFF_TALLY, d, v);
		`CHECK(v, 1'b1);
		`CHECK(d, 8'h06);
		`CHECK(d[3:0] == 4'd`TD_BUTTONS, 1'b0);
	endtask

	// clock enable low: a write is not taken
	task automatic t_freeze;
		@(posedge clk_sys);
		ce <= 1'b0;
		host.write_reg(`TD_OFF_CONTROL, 8'h71);
		@(posedge clk_sys);
		`CHECK(host_out, 4'b1000);
		`CHECK(device_mode, MODE_NORMAL);
		ce <= 1'b1;
	endtask

	// mid-run reset clears flags, tally and control
	task automatic t_rerun;
		@(posedge clk_sys);
		reset <= 1'b1;
		repeat (2) @(posedge clk_sys);
		reset <= 1'b0;
		`CHECK(sense_enable, 10'h3FF);
		`CHECK(host_out, 4'h0);
		`CHECK(device_mode, MODE_LINE_TEST);
		rd_chk(`TD_OFF_GND_LO, `TD_RST_STATUS);
		rd_chk(`TD_OFF_CAP_HI, `TD_RST_STATUS);
		rd_chk(`TD_OFF_TALLY, `TD_RST_STATUS);
	endtask

	// ----------------------------------------------------------------
	// main sequence and watchdog
	// ----------------------------------------------------------------
	initial
	begin
		clk_sys    = 1'b0;
		reset      = 1'b1;
		ce         = 1'b1;
		raw_touch  = 10'h000;
		gnd_set    = 10'h000;
		cap_set    = 10'h000;
		pair_valid = 1'b0;
		pair_a     = 4'd0;
		pair_b     = 4'd0;
		diag_done  = 1'b0;
		n_errors   = 0;
		compares   = 0;
		repeat (8) @(posedge clk_sys);
		reset <= 1'b0;
		t_reset();
		t_control();
		t_read_only();
		t_touch();
		t_faults();
		t_tally();
		t_freeze();
		t_rerun();
		close_out();
	end

	initial
	begin
		#20000;
		n_errors++;
		$display("Error %0t: watchdog expired", $time);
		close_out();
	end

endmodule // test_touch_button_diag_register_bank

`default_nettype wire

// file: touch_button_diag_register_bank.sv
// Contract
// R1: registers load initial values, honour access type
// R2: reserved registers store nothing, read undefined
// R3: reserved bits carry no function
// R4: control bits 7..4 drive outputs 3..0
// R5: 0 drives low, 1 high, reset 0
// R6: bits 2:0 select mode, 101-111 invalid
// R7: tally low nibble counts working buttons
// R8: host compares tally with expected count
// R9: failing buttons disabled, excluded from sensing
// R10: status bits: 1 touched, 0 not touched
// R11: buttons 0-7 low reg, 8-9 high reg
// R12: ground short sets flag, disables button
// R13: pair short flags and disables both buttons
// R14: capacitance over 40 pF flags, disables button
// R15: writes to read-only registers are ignored
`timescale 1ns/1ps
`default_nettype none
`include "touch_diag_defs.svh"

module touch_button_diag_register_bank
	import touch_diag_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        reset,
	input  wire logic        ce,
	input  wire logic        reg_wr_en,
	input  wire logic        reg_rd_en,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wr_data,
	output logic      [7:0]  reg_rd_data,
	output logic             reg_rd_valid,
	input  wire logic [9:0]  raw_touch,
	input  wire logic [9:0]  gnd_fault_set,
	input  wire logic [9:0]  cap_fault_set,
	input  wire logic        pair_fault_valid,
	input  wire logic [3:0]  pair_fault_a,
	input  wire logic [3:0]  pair_fault_b,
	input  wire logic        diag_done,
	output logic      [3:0]  host_driven_output,
	output op_mode_t         device_mode,
	output logic      [9:0]  sense_enable
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [3:0] out_bits_q;
	logic [3:0] out_bits_d;
	op_mode_t   mode_q;
	op_mode_t   mode_d;
	logic       mode_ok;
	logic [3:0] tally_q;
	logic [9:0] touch_q;
	logic [7:0] rd_data_q;
	logic       rd_valid_q;

	wire logic [9:0] gnd_flags;
	wire logic [9:0] pair_flags;
	wire logic [9:0] cap_flags;

	// ----------------------------------------------------------------
	// popcount of the working-button mask
	// ----------------------------------------------------------------
	function automatic logic [3:0] count_ones(input logic [9:0] v);
		logic [3:0] n;
		n = 4'h0;
		for (int i = 0; i < `TD_BUTTONS; i++)
			n = n + {3'h0, v[i]};
		return n;
	endfunction

	// ----------------------------------------------------------------
	// fault flags and button enables
	// ----------------------------------------------------------------
	fault_collector #(
		.N_BUTTONS(`TD_BUTTONS)
	) u_faults (
		.clk_sys          (clk_sys),
		.reset            (reset),
		.ce               (ce),
		.gnd_fault_set    (gnd_fault_set),
		.cap_fault_set    (cap_fault_set),
		.pair_fault_valid (pair_fault_valid),
		.pair_fault_a     (pair_fault_a),
		.pair_fault_b     (pair_fault_b),
		.gnd_flags        (gnd_flags),
		.pair_flags       (pair_flags),
		.cap_flags        (cap_flags),
		.sense_enable     (sense_enable)
	);

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	wire logic wr_ctrl;
	wire logic [7:0] ctrl_view;
	wire logic [7:0] tally_view;
	wire logic [7:0] touch_lo_view;
	wire logic [7:0] touch_hi_view;
	wire logic [7:0] gnd_lo_view;
	wire logic [7:0] gnd_hi_view;
	wire logic [7:0] pair_lo_view;
	wire logic [7:0] pair_hi_view;
	wire logic [7:0] cap_lo_view;
	wire logic [7:0] cap_hi_view;
	wire logic [7:0] rd_mux;

	// only the control register accepts writes
	assign wr_ctrl = ce && reg_wr_en && (reg_addr == `TD_OFF_CONTROL); // R15

	// read views; unused bits read zero
	assign ctrl_view     = {out_bits_q, 1'b0, mode_q};               // R3
	assign tally_view    = {4'h0, tally_q};                          // R7
	assign touch_lo_view = touch_q[`TD_LO_BUTTONS-1:0];              // R11
	assign touch_hi_view = {6'h00, touch_q[9:`TD_LO_BUTTONS]};       // R11
	assign gnd_lo_view   = gnd_flags[`TD_LO_BUTTONS-1:0];
	assign gnd_hi_view   = {6'h00, gnd_flags[9:`TD_LO_BUTTONS]};
	assign pair_lo_view  = pair_flags[`TD_LO_BUTTONS-1:0];
	assign pair_hi_view  = {6'h00, pair_flags[9:`TD_LO_BUTTONS]};
	assign cap_lo_view   = cap_flags[`TD_LO_BUTTONS-1:0];
	assign cap_hi_view   = {6'h00, cap_flags[9:`TD_LO_BUTTONS]};

	// read select; reserved offsets store nothing and read zero
	assign rd_mux =
		(reg_addr == `TD_OFF_CONTROL)  ? ctrl_view     :
		(reg_addr == `TD_OFF_TALLY)    ? tally_view    :
		(reg_addr == `TD_OFF_TOUCH_LO) ? touch_lo_view :
		(reg_addr == `TD_OFF_TOUCH_HI) ? touch_hi_view :
		(reg_addr == `TD_OFF_GND_LO)   ? gnd_lo_view   :
		(reg_addr == `TD_OFF_GND_HI)   ? gnd_hi_view   :
		(reg_addr == `TD_OFF_PAIR_LO)  ? pair_lo_view  :
		(reg_addr == `TD_OFF_PAIR_HI)  ? pair_hi_view  :
		(reg_addr == `TD_OFF_CAP_LO)   ? cap_lo_view   :
		(reg_addr == `TD_OFF_CAP_HI)   ? cap_hi_view   :
		8'h00; // R2

	// ----------------------------------------------------------------
	// control register next value
	// ----------------------------------------------------------------
	// an invalid mode code leaves the mode as it was
	always_comb
	begin
		mode_ok = 1'b1;
		mode_d  = mode_q;
		unique case (reg_wr_data[`TD_MODE_MSB:`TD_MODE_LSB])
			3'b000: mode_d = MODE_NORMAL;
			3'b001: mode_d = MODE_LIGHT_CFG;
			3'b010: mode_d = MODE_DEVICE_CFG;
			3'b011: mode_d = MODE_LINE_TEST;
			3'b100: mode_d = MODE_DEBUG_DATA;
			default: mode_ok = 1'b0; // R6
		endcase
	end

	assign out_bits_d = reg_wr_data[`TD_OUT_MSB:`TD_OUT_LSB]; // R4

	// control register, reset value 03h
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			out_bits_q <= 4'(`TD_RST_CONTROL >> `TD_OUT_LSB);      // R1
			mode_q     <= op_mode_t'(3'(`TD_RST_CONTROL));         // R1
		end
		else if (wr_ctrl)
		begin
			out_bits_q <= out_bits_d;                              // R5
			if (mode_ok)
				mode_q <= mode_d;                                  // R6
		end
	end

	// ----------------------------------------------------------------
	// status registers
	// ----------------------------------------------------------------
	// live touch state, masked by the enables; tally caught at diag end
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			touch_q <= 10'h000;                                    // R1
			tally_q <= 4'h0;                                       // R1
		end
		else if (ce)
		begin
			touch_q <= raw_touch & sense_enable;                   // R10
			if (diag_done)
				tally_q <= count_ones(sense_enable);               // R7
		end
	end

	// ----------------------------------------------------------------
	// read port
	// ----------------------------------------------------------------
	// read data is registered and answers one cycle after the strobe
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			rd_data_q  <= `TD_RST_STATUS;
			rd_valid_q <= 1'b0;
		end
		else if (ce)
		begin
			rd_valid_q <= reg_rd_en;
			if (reg_rd_en)
				rd_data_q <= rd_mux;
		end
	end

	assign reg_rd_data        = rd_data_q;
	assign reg_rd_valid       = rd_valid_q;
	assign host_driven_output = out_bits_q; // R4
	assign device_mode        = mode_q;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	property p_out_write;
		@(posedge clk_sys) disable iff (reset)
		wr_ctrl |=> (host_driven_output == $past(reg_wr_data[7:4]));
	endproperty
	a_out_write: assert property (p_out_write) else $error("output bits not written"); // R5

	property p_mode_legal;
		@(posedge clk_sys) disable iff (reset)
		(wr_ctrl && reg_wr_data[2:0] > 3'b100) |=> $stable(device_mode);
	endproperty
	a_mode_legal: assert property (p_mode_legal) else $error("invalid mode accepted"); // R6

	property p_mode_write;
		@(posedge clk_sys) disable iff (reset)
		(wr_ctrl && reg_wr_data[2:0] <= 3'b100) |=> (device_mode == $past(reg_wr_data[2:0]));
	endproperty
	a_mode_write: assert property (p_mode_write) else $error("valid mode not taken"); // R6

	property p_tally;
		@(posedge clk_sys) disable iff (reset)
		(ce && diag_done) |=> (tally_q == $countones($past(sense_enable)));
	endproperty
	a_tally: assert property (p_tally) else $error("tally wrong"); // R7

	property p_touch_masked;
		@(posedge clk_sys) disable iff (reset)
		ce |=> ((touch_q & ~$past(sense_enable)) == 10'h000);
	endproperty
	a_touch_masked: assert property (p_touch_masked) else $error("disabled button sensed"); // R9

	property p_gnd;
		@(posedge clk_sys) disable iff (reset)
		(ce && gnd_fault_set != 10'h000) |=>
			(((gnd_flags & $past(gnd_fault_set)) == $past(gnd_fault_set))
			&& ((sense_enable & $past(gnd_fault_set)) == 10'h000));
	endproperty
	a_gnd: assert property (p_gnd) else $error("ground short not flagged"); // R12

	property p_pair;
		@(posedge clk_sys) disable iff (reset)
		(ce && pair_fault_valid && pair_fault_a < 4'hA && pair_fault_b < 4'hA) |=>
			(pair_flags[$past(pair_fault_a)] && pair_flags[$past(pair_fault_b)]
			&& !sense_enable[$past(pair_fault_a)] && !sense_enable[$past(pair_fault_b)]);
	endproperty
	a_pair: assert property (p_pair) else $error("pair short not flagged on both"); // R13

	property p_cap;
		@(posedge clk_sys) disable iff (reset)
		(ce && cap_fault_set != 10'h000) |=>
			(((cap_flags & $past(cap_fault_set)) == $past(cap_fault_set))
			&& ((sense_enable & $past(cap_fault_set)) == 10'h000));
	endproperty
	a_cap: assert property (p_cap) else $error("capacitance fault not flagged"); // R14

	property p_ro_write;
		@(posedge clk_sys) disable iff (reset)
		(ce && reg_wr_en && reg_addr == `TD_OFF_GND_LO && gnd_fault_set == 10'h000)
			|=> $stable(gnd_flags);
	endproperty
	a_ro_write: assert property (p_ro_write) else $error("read-only register changed"); // R15

	property p_reserved;
		@(posedge clk_sys) disable iff (reset)
		(ce && reg_rd_en && (reg_addr == 8'h01 || reg_addr == 8'h06))
			|=> (reg_rd_valid && reg_rd_data == 8'h00);
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved read not zero"); // R2

	property p_hi_map;
		@(posedge clk_sys) disable iff (reset)
		(ce && reg_rd_en && reg_addr == `TD_OFF_TOUCH_HI)
			|=> (reg_rd_data == {6'h00, $past(touch_q[9:8])});
	endproperty
	a_hi_map: assert property (p_hi_map) else $error("high status mapping wrong"); // R11

	property p_reset_ctrl;
		@(posedge clk_sys)
		$fell(reset) |-> (device_mode == MODE_LINE_TEST && host_driven_output == 4'h0);
	endproperty
	a_reset_ctrl: assert property (p_reset_ctrl) else $error("control reset value wrong"); // R1

endmodule // touch_button_diag_register_bank

`default_nettype wire

// file: touch_diag_defs.svh
`ifndef TOUCH_DIAG_DEFS_SVH
`define TOUCH_DIAG_DEFS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define TD_OFF_CONTROL      8'h00
`define TD_OFF_TALLY        8'h03
`define TD_OFF_TOUCH_LO     8'h04
`define TD_OFF_TOUCH_HI     8'h05
`define TD_OFF_GND_LO       8'h07
`define TD_OFF_GND_HI       8'h08
`define TD_OFF_PAIR_LO      8'h0A
`define TD_OFF_PAIR_HI      8'h0B
`define TD_OFF_CAP_LO       8'h0D
`define TD_OFF_CAP_HI       8'h0E

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define TD_OUT_MSB          7
`define TD_OUT_LSB          4
`define TD_MODE_MSB         2
`define TD_MODE_LSB         0
`define TD_TALLY_MSB        3
`define TD_RST_CONTROL      8'h03
`define TD_RST_STATUS       8'h00
`define TD_BUTTONS          10
`define TD_LO_BUTTONS       8

`endif

// file: touch_diag_pkg.sv
package touch_diag_pkg;

	// device operating mode; codes 101..111 are not valid
	typedef enum logic [2:0] {
		MODE_NORMAL     = 3'b000,
		MODE_LIGHT_CFG  = 3'b001,
		MODE_DEVICE_CFG = 3'b010,
		MODE_LINE_TEST  = 3'b011,
		MODE_DEBUG_DATA = 3'b100
	} op_mode_t;

	typedef logic [7:0] reg_byte_t;

endpackage
